// File: design/aob_dly_mem.sv
// Small delay memory with registered read data.
`default_nettype none
module aob_dly_mem #(
    parameter int DW = 26,
    parameter int AW = 4
) (
    input wire logic clk,
    aob_mem_if.mem port
);
    logic [DW-1:0] store [2**AW];

    always_ff @(posedge clk)
    begin
        if (port.we)
        begin
            store[port.waddr] <= port.wdata;
        end
        port.rdata <= store[port.raddr];
    end
endmodule
`default_nettype wire

// File: design/aob_lfsr.sv
// Fibonacci pseudorandom generator with reseed and step.
`default_nettype none
module aob_lfsr #(
    parameter int WIDTH = 9,
    parameter logic [WIDTH-1:0] TAPS = '1,
    parameter logic [WIDTH-1:0] SEED = '1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic reseed,
    input wire logic step,
    output logic [WIDTH-1:0] value
);
    always_ff @(posedge clk)
    begin
        if (rst || reseed)
        begin
            value <= SEED;
        end
        else if (step)
        begin
            value <= {value[WIDTH-2:0], ^(value & TAPS)};
        end
    end
endmodule
`default_nettype wire

// File: design/aob_mem_if.sv
// Port bundle between the back end and its latency memory.
`default_nettype none
interface aob_mem_if #(
    parameter int DW = 26,
    parameter int AW = 4
);
    logic we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// File: design/aob_pkg.sv
// Shared constants of the converter output back end.
`default_nettype none
package aob_pkg;
    localparam logic [7:0] OFS_TEST_PATTERN = 8'h0D;
    localparam logic [7:0] OFS_BIST_CTRL = 8'h0E;
    localparam logic [7:0] OFS_OUT_MODE = 8'h14;
    localparam logic [7:0] OFS_BIST_STATUS = 8'h24;
    localparam logic [7:0] RST_TEST_PATTERN = 8'h00;
    localparam logic [7:0] RST_BIST_CTRL = 8'h00;
    localparam logic [7:0] RST_OUT_MODE = 8'h00;
    localparam int BIT_BIST_EN = 0;
    localparam int BIT_BIST_RESEED = 2;
    localparam int BIT_BIST_PASS = 0;
    localparam int BIT_BIST_BUSY = 1;
    localparam int BIT_OUT_DISABLE = 4;
    localparam int BIT_STROBE_INV = 5;
    localparam int BIT_MUX = 7;
    localparam int BIT_PN_LONG_RST = 4;
    localparam int BIT_PN_SHORT_RST = 5;
    localparam int PIPE_LATENCY = 9;
    localparam int BIST_CYCLES = 512;
    typedef enum logic [1:0] {FMT_OFFSET, FMT_TWOS, FMT_GRAY} aob_fmt_e;
    localparam logic [3:0] PAT_OFF = 4'h0;
    localparam logic [3:0] PAT_MID = 4'h1;
    localparam logic [3:0] PAT_POS = 4'h2;
    localparam logic [3:0] PAT_NEG = 4'h3;
    localparam logic [3:0] PAT_CHECKER = 4'h4;
    localparam logic [3:0] PAT_PN_LONG = 4'h5;
    localparam logic [3:0] PAT_PN_SHORT = 4'h6;
    localparam logic [3:0] PAT_TOGGLE = 4'h7;
    localparam int PN_LONG_W = 23;
    localparam logic [22:0] PN_LONG_TAPS = 23'h420000;
    localparam logic [22:0] PN_LONG_SEED = 23'h7FFFFF;
    localparam logic [22:0] BIST_SEED = 23'h2AAAAA;
    localparam int PN_SHORT_W = 9;
    localparam logic [8:0] PN_SHORT_TAPS = 9'h110;
    localparam logic [8:0] PN_SHORT_SEED = 9'h1FF;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] BIST_SIG_GOLDEN = 16'h0000;
    localparam int MEM_AW = 4;
endpackage
`default_nettype wire

// File: design/aob_top.sv
// Output back end: formatting, three-state, latency, strobes, self-test, patterns.
`default_nettype none
module aob_top #(
    parameter int DW = 12,
    parameter int BIST_LEN = aob_pkg::BIST_CYCLES,
    parameter logic [15:0] BIST_GOLDEN = aob_pkg::BIST_SIG_GOLDEN
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic link_clk,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [1:0] reg_chan,
    output logic [7:0] reg_rdata,
    input wire logic serial_mode,
    input wire logic format_select_strap,
    input wire logic output_disable,
    input wire logic [DW-1:0] conv_a,
    input wire logic conv_a_ovr,
    input wire logic [DW-1:0] conv_b,
    input wire logic conv_b_ovr,
    output logic [DW:0] data_a_out,
    output logic data_a_oe,
    output logic [DW:0] data_b_out,
    output logic data_b_oe,
    output logic sample_strobe_a_out,
    output logic sample_strobe_a_oe,
    output logic sample_strobe_b_out,
    output logic sample_strobe_b_oe
);
    localparam int WW = 2 * DW + 2;
    localparam int AW = aob_pkg::MEM_AW;
    localparam int CW = $clog2(BIST_LEN + 1);
    localparam logic [AW-1:0] RD_BACK = AW'(aob_pkg::PIPE_LATENCY - 1);
    localparam logic [3:0] FILL_MAX = 4'(aob_pkg::PIPE_LATENCY - 1);
    localparam logic [CW-1:0] LAST_CNT = CW'(BIST_LEN - 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(BIST_LEN);
    localparam logic [DW-1:0] MID_CODE = {1'b1, {(DW-1){1'b0}}};
    localparam logic [DW-1:0] CHECK_CODE = DW'({(DW/2+1){2'b01}});

    typedef enum logic [1:0] {B_IDLE, B_RUN, B_DRAIN, B_CHECK} aob_bist_e;

    function automatic aob_pkg::aob_fmt_e pick_fmt(input logic ser, input logic strap,
                                                    input logic [1:0] field);
        if (ser)
        begin
            return aob_pkg::aob_fmt_e'(field);
        end
        return strap ? aob_pkg::FMT_TWOS : aob_pkg::FMT_OFFSET;
    endfunction

    function automatic logic [DW-1:0] fmt_word(input logic [DW-1:0] w,
                                               input aob_pkg::aob_fmt_e f, input logic raw);
        if (raw)
        begin
            return w;
        end
        if (f == aob_pkg::FMT_TWOS)
        begin
            return {~w[DW-1], w[DW-2:0]};
        end
        if (f == aob_pkg::FMT_GRAY)
        begin
            return w ^ (w >> 1);
        end
        return w;
    endfunction

    // Returns the raw flag above the pattern word.
    function automatic logic [DW:0] pat_word(input logic [3:0] m, input logic alt,
                                             input logic [DW-1:0] pl,
                                             input logic [DW-1:0] ps);
        case (m)
            aob_pkg::PAT_MID: return {1'b0, MID_CODE};
            aob_pkg::PAT_POS: return {1'b0, {DW{1'b1}}};
            aob_pkg::PAT_NEG: return {1'b0, {DW{1'b0}}};
            aob_pkg::PAT_CHECKER: return {1'b1, alt ? ~CHECK_CODE : CHECK_CODE};
            aob_pkg::PAT_PN_LONG: return {1'b0, pl};
            aob_pkg::PAT_PN_SHORT: return {1'b0, ps};
            aob_pkg::PAT_TOGGLE: return {1'b1, {DW{alt}}};
            default: return {1'b0, MID_CODE};
        endcase
    endfunction

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [WW-1:0] d);
        logic [15:0] r;
        r = c;
        for (int i = WW - 1; i >= 0; i--)
        begin
            r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? aob_pkg::CRC_POLY : 16'h0000);
        end
        return r;
    endfunction

    // Register side, on clk.
    logic [7:0] pat_reg;
    logic [7:0] bist_ctl_reg;
    logic [7:0] mode_a_reg;
    logic [7:0] mode_b_reg;
    logic start_tgl_reg;
    logic busy_reg;
    logic [1:0] res_s1_reg;
    logic [1:0] res_s2_reg;
    logic done_seen_reg;
    logic pass_reg;
    logic done_tgl_reg;
    logic [7:0] rdata_next;

    wire wr_pat = reg_wr && reg_addr == aob_pkg::OFS_TEST_PATTERN;
    wire wr_bist = reg_wr && reg_addr == aob_pkg::OFS_BIST_CTRL;
    wire wr_mode = reg_wr && reg_addr == aob_pkg::OFS_OUT_MODE;
    wire bist_go = wr_bist && reg_wdata[aob_pkg::BIT_BIST_EN];
    wire done_edge = res_s2_reg[1] ^ done_seen_reg;
    wire [7:0] status_rd = {6'h00, busy_reg, res_s2_reg[0]};
    wire [7:0] mode_rd = reg_chan[0] ? mode_a_reg : mode_b_reg;

    assign rdata_next = reg_addr == aob_pkg::OFS_TEST_PATTERN ? pat_reg :
                        reg_addr == aob_pkg::OFS_BIST_CTRL ? bist_ctl_reg :
                        reg_addr == aob_pkg::OFS_OUT_MODE ? mode_rd :
                        reg_addr == aob_pkg::OFS_BIST_STATUS ? status_rd : 8'h00;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pat_reg <= aob_pkg::RST_TEST_PATTERN;
            bist_ctl_reg <= aob_pkg::RST_BIST_CTRL;
            mode_a_reg <= aob_pkg::RST_OUT_MODE;
            mode_b_reg <= aob_pkg::RST_OUT_MODE;
            reg_rdata <= 8'h00;
        end
        else
        begin
            pat_reg <= wr_pat ? reg_wdata : pat_reg;
            bist_ctl_reg <= wr_bist ? reg_wdata : bist_ctl_reg;
            mode_a_reg <= (wr_mode && reg_chan[0]) ? reg_wdata : mode_a_reg;
            mode_b_reg <= (wr_mode && reg_chan[1]) ? reg_wdata : mode_b_reg;
            reg_rdata <= rdata_next;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            start_tgl_reg <= 1'b0;
            busy_reg <= 1'b0;
            res_s1_reg <= 2'h0;
            res_s2_reg <= 2'h0;
            done_seen_reg <= 1'b0;
        end
        else
        begin
            start_tgl_reg <= start_tgl_reg ^ bist_go;
            busy_reg <= bist_go || (busy_reg && !done_edge);
            res_s1_reg <= {done_tgl_reg, pass_reg};
            res_s2_reg <= res_s1_reg;
            done_seen_reg <= res_s2_reg[1];
        end
    end

    // Link side, on link_clk.
    logic [1:0] lrst_sync_reg;
    logic [31:0] cfg_s1_reg;
    logic [31:0] cfg_s2_reg;
    logic [2:0] pin_s1_reg;
    logic [2:0] pin_s2_reg;
    logic [2:0] st_sync_reg;
    logic phase_reg;
    logic alt_reg;
    logic [DW+1:0] in_a_reg;
    logic [DW+1:0] in_b_reg;
    logic in_bist_reg;
    logic [AW-1:0] wptr_reg;
    logic [3:0] fill_reg;
    aob_bist_e bstate_reg;
    logic [CW-1:0] bcnt_reg;
    logic [CW-1:0] acc_cnt_reg;
    logic [15:0] misr_reg;
    logic [aob_pkg::PN_LONG_W-1:0] pnl;
    logic [aob_pkg::PN_SHORT_W-1:0] pns;
    logic [aob_pkg::PN_LONG_W-1:0] bist_pn;

    wire lrst = lrst_sync_reg[1];
    wire [7:0] pat_s = cfg_s2_reg[7:0];
    wire [7:0] bctl_s = cfg_s2_reg[15:8];
    wire [7:0] mode_a_s = cfg_s2_reg[23:16];
    wire [7:0] mode_b_s = cfg_s2_reg[31:24];
    wire serial_s = pin_s2_reg[0];
    wire strap_s = pin_s2_reg[1];
    wire dis_s = pin_s2_reg[2];
    wire start_edge = st_sync_reg[2] ^ st_sync_reg[1];
    wire tick = phase_reg;
    wire test_on = pat_s[3:0] != aob_pkg::PAT_OFF;
    wire bist_inj = bstate_reg == B_RUN;
    wire reseed = start_edge && bctl_s[aob_pkg::BIT_BIST_RESEED];
    wire mux_a = serial_s && mode_a_s[aob_pkg::BIT_MUX];
    wire inv_a = serial_s && mode_a_s[aob_pkg::BIT_STROBE_INV];
    wire inv_b = serial_s && mode_b_s[aob_pkg::BIT_STROBE_INV];
    wire keep_on = bstate_reg != B_IDLE;
    wire oe_a_next = !dis_s && (keep_on || !(serial_s && mode_a_s[aob_pkg::BIT_OUT_DISABLE]));
    wire oe_b_next = !dis_s && (keep_on || !(serial_s && mode_b_s[aob_pkg::BIT_OUT_DISABLE]));
    wire [DW-1:0] ps_word = DW'({pns, pns});
    wire [DW:0] pat_a = pat_word(pat_s[3:0], alt_reg, pnl[DW-1:0], ps_word);
    wire [DW:0] pat_b = pat_word(pat_s[3:0], alt_reg, pnl[aob_pkg::PN_LONG_W-1 -: DW], ~ps_word);
    wire [DW-1:0] src_a = bist_inj ? bist_pn[DW-1:0] : test_on ? pat_a[DW-1:0] : conv_a;
    wire [DW-1:0] src_b = bist_inj ? bist_pn[aob_pkg::PN_LONG_W-1 -: DW] :
                          test_on ? pat_b[DW-1:0] : conv_b;
    wire raw_a = !bist_inj && test_on && pat_a[DW];
    wire raw_b = !bist_inj && test_on && pat_b[DW];
    wire ovr_a = !bist_inj && !test_on && conv_a_ovr;
    wire ovr_b = !bist_inj && !test_on && conv_b_ovr;
    wire aob_pkg::aob_fmt_e fmt_a = pick_fmt(serial_s, strap_s, mode_a_s[1:0]);
    wire aob_pkg::aob_fmt_e fmt_b = pick_fmt(serial_s, strap_s, mode_b_s[1:0]);
    wire [DW-1:0] word_a = fmt_word(in_a_reg[DW-1:0], fmt_a, in_a_reg[DW]);
    wire [DW-1:0] word_b = fmt_word(in_b_reg[DW-1:0], fmt_b, in_b_reg[DW]);
    wire out_ok = fill_reg == FILL_MAX;

    aob_mem_if #(.DW(WW), .AW(AW)) mif ();

    assign mif.we = tick;
    assign mif.waddr = wptr_reg;
    assign mif.wdata = {in_b_reg[DW+1], word_b, in_a_reg[DW+1], word_a};
    assign mif.raddr = wptr_reg - RD_BACK;

    aob_dly_mem #(.DW(WW), .AW(AW)) u_mem (
        .clk(link_clk),
        .port(mif.mem)
    );

    aob_lfsr #(
        .WIDTH(aob_pkg::PN_LONG_W),
        .TAPS(aob_pkg::PN_LONG_TAPS),
        .SEED(aob_pkg::PN_LONG_SEED)
    ) u_pn_long (
        .clk(link_clk),
        .rst(lrst),
        .reseed(pat_s[aob_pkg::BIT_PN_LONG_RST]),
        .step(tick),
        .value(pnl)
    );

    aob_lfsr #(
        .WIDTH(aob_pkg::PN_SHORT_W),
        .TAPS(aob_pkg::PN_SHORT_TAPS),
        .SEED(aob_pkg::PN_SHORT_SEED)
    ) u_pn_short (
        .clk(link_clk),
        .rst(lrst),
        .reseed(pat_s[aob_pkg::BIT_PN_SHORT_RST]),
        .step(tick),
        .value(pns)
    );

    aob_lfsr #(
        .WIDTH(aob_pkg::PN_LONG_W),
        .TAPS(aob_pkg::PN_LONG_TAPS),
        .SEED(aob_pkg::BIST_SEED)
    ) u_pn_bist (
        .clk(link_clk),
        .rst(lrst),
        .reseed(reseed),
        .step(tick && bist_inj),
        .value(bist_pn)
    );

    // Configuration words are quasi-static; the start edge shows in the same cycle as the new cfg_s2_reg.
    always_ff @(posedge link_clk)
    begin
        lrst_sync_reg <= {lrst_sync_reg[0], sys_rst};
        cfg_s1_reg <= {mode_b_reg, mode_a_reg, bist_ctl_reg, pat_reg};
        cfg_s2_reg <= cfg_s1_reg;
        pin_s1_reg <= {output_disable, format_select_strap, serial_mode};
        pin_s2_reg <= pin_s1_reg;
        st_sync_reg <= {st_sync_reg[1:0], start_tgl_reg};
    end

    always_ff @(posedge link_clk)
    begin
        if (lrst)
        begin
            phase_reg <= 1'b0;
            alt_reg <= 1'b0;
            in_a_reg <= '0;
            in_b_reg <= '0;
            in_bist_reg <= 1'b0;
            wptr_reg <= '0;
            fill_reg <= 4'h0;
        end
        else
        begin
            phase_reg <= ~phase_reg;
            alt_reg <= alt_reg ^ tick;
            in_a_reg <= tick ? {ovr_a, raw_a, src_a} : in_a_reg;
            in_b_reg <= tick ? {ovr_b, raw_b, src_b} : in_b_reg;
            in_bist_reg <= tick ? bist_inj : in_bist_reg;
            wptr_reg <= wptr_reg + AW'(tick);
            fill_reg <= (tick && !out_ok) ? fill_reg + 4'h1 : fill_reg;
        end
    end

    always_ff @(posedge link_clk)
    begin
        if (lrst)
        begin
            data_a_out <= '0;
            data_b_out <= '0;
        end
        else if (tick)
        begin
            data_a_out <= out_ok ? mif.rdata[DW:0] : '0;
            data_b_out <= out_ok ? mif.rdata[WW-1:DW+1] : '0;
        end
        else if (mux_a)
        begin
            data_a_out <= data_b_out;
        end
    end

    always_ff @(posedge link_clk)
    begin
        if (lrst)
        begin
            data_a_oe <= 1'b0;
            data_b_oe <= 1'b0;
            sample_strobe_a_oe <= 1'b0;
            sample_strobe_b_oe <= 1'b0;
            sample_strobe_a_out <= 1'b0;
            sample_strobe_b_out <= 1'b0;
        end
        else
        begin
            data_a_oe <= oe_a_next;
            data_b_oe <= oe_b_next;
            sample_strobe_a_oe <= oe_a_next;
            sample_strobe_b_oe <= oe_b_next;
            sample_strobe_a_out <= ~phase_reg ^ inv_a;
            sample_strobe_b_out <= ~phase_reg ^ inv_b;
        end
    end

    always_ff @(posedge link_clk)
    begin
        if (lrst)
        begin
            bstate_reg <= B_IDLE;
            bcnt_reg <= '0;
        end
        else if (start_edge)
        begin
            bstate_reg <= B_RUN;
            bcnt_reg <= '0;
        end
        else
        begin
            unique case (bstate_reg)
                B_IDLE: bstate_reg <= B_IDLE;
                B_RUN: bstate_reg <= (tick && bcnt_reg == LAST_CNT) ? B_DRAIN : B_RUN;
                B_DRAIN: bstate_reg <= tick ? B_CHECK : B_DRAIN;
                B_CHECK: bstate_reg <= B_IDLE;
            endcase
            bcnt_reg <= bcnt_reg + CW'(tick && bist_inj);
        end
    end

    // The signature covers only words that entered while injection was on.
    always_ff @(posedge link_clk)
    begin
        if (lrst)
        begin
            misr_reg <= aob_pkg::CRC_INIT;
            acc_cnt_reg <= '0;
            pass_reg <= 1'b0;
            done_tgl_reg <= 1'b0;
        end
        else if (start_edge)
        begin
            misr_reg <= aob_pkg::CRC_INIT;
            acc_cnt_reg <= '0;
            pass_reg <= 1'b0;
        end
        else
        begin
            if (tick && in_bist_reg && keep_on)
            begin
                misr_reg <= crc_step(misr_reg, mif.wdata);
                acc_cnt_reg <= acc_cnt_reg + CW'(1);
            end
            if (bstate_reg == B_CHECK)
            begin
                pass_reg <= misr_reg == BIST_GOLDEN;
                done_tgl_reg <= ~done_tgl_reg;
            end
        end
    end

    lat_pipe_a: assert property (@(posedge link_clk) disable iff (lrst)
        (tick && out_ok && !mux_a) ##17 !mux_a |->
            data_a_out == $past(mif.wdata[DW:0], 17))
        else $error("sample did not appear nine ticks later");
    twos_msb_a: assert property (@(posedge link_clk) disable iff (lrst)
        (fmt_a == aob_pkg::FMT_TWOS && !in_a_reg[DW]) |->
            mif.wdata[DW-1] == ~in_a_reg[DW-1])
        else $error("twos complement did not invert the top bit");
    pin_float_a: assert property (@(posedge link_clk) disable iff (lrst)
        dis_s |=> !data_a_oe && !data_b_oe && !sample_strobe_a_oe && !sample_strobe_b_oe)
        else $error("outputs driven while disable pin high");
    bist_len_a: assert property (@(posedge link_clk) disable iff (lrst)
        bstate_reg == B_CHECK |-> acc_cnt_reg == FULL_CNT)
        else $error("self-test word count wrong");
    pass_flag_a: assert property (@(posedge link_clk) disable iff (lrst)
        (bstate_reg == B_CHECK && !start_edge) |=> pass_reg == ($past(misr_reg) == BIST_GOLDEN))
        else $error("pass flag disagrees with signature");
    bist_seed_a: assert property (@(posedge link_clk) disable iff (lrst)
        reseed |=> bist_pn == aob_pkg::BIST_SEED)
        else $error("self-test generator not reseeded");
    pat_reset_a: assert property (@(posedge link_clk) disable iff (lrst)
        pat_s[aob_pkg::BIT_PN_LONG_RST] |=> pnl == aob_pkg::PN_LONG_SEED)
        else $error("pattern generator not reset");
    pat_hold_a: assert property (@(posedge link_clk) disable iff (lrst)
        (!tick && !pat_s[aob_pkg::BIT_PN_SHORT_RST]) |=> $stable(pns))
        else $error("pattern advanced without a sample tick");
    bist_drive_a: assert property (@(posedge link_clk) disable iff (lrst)
        (bist_inj && !dis_s) |=> data_a_oe && data_b_oe)
        else $error("outputs floated during self-test");
    strobe_mid_a: assert property (@(posedge link_clk) disable iff (lrst)
        (tick && !inv_a) |=> !sample_strobe_a_out ##1 sample_strobe_a_out)
        else $error("strobe not rising mid-word");
endmodule
`default_nettype wire

// File: dv/aob_capture_model.sv
// Far-side capture register that latches bus A on its strobe.
`default_nettype none
module aob_capture_model (
    input wire logic sample_strobe_a_out,
    input wire logic [12:0] data_a_out,
    output logic [12:0] cap_a
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge sample_strobe_a_out) cap_a <= data_a_out;
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Register- and pin-driven tests of the output back end with a capture model.
`default_nettype none
`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("ERROR %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, link_clk = 0, sys_rst = 1, reg_wr = 0, serial_mode = 1;
    logic format_select_strap = 0, output_disable = 0, conv_a_ovr = 0, conv_b_ovr = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic [1:0] reg_chan = 0;
    logic [11:0] conv_a = 0, conv_b = 12'h123;
    logic [12:0] data_a_out, data_b_out, cap_a, v1;
    logic data_a_oe, data_b_oe, sample_strobe_a_out, sample_strobe_a_oe;
    logic sample_strobe_b_out, sample_strobe_b_oe;
    int miscompares = 0, num_checks = 0, cycles = 0, n;
    logic [12:0] lin [3] = '{13'h18A5, 13'h03C0, 13'h05A5};
    logic [12:0] lexp [3] = '{13'h18A5, 13'h0BC0, 13'h0777};
    logic [12:0] bexp [3] = '{13'h0123, 13'h0923, 13'h01B2};
    logic [3:0] pats [3] = '{aob_pkg::PAT_MID, aob_pkg::PAT_POS, aob_pkg::PAT_NEG};
    logic [11:0] pexp [3] = '{12'h800, 12'hFFF, 12'h000};
    always #12.5 clk = ~clk;
    always #6 link_clk = ~link_clk;
    aob_top #(.BIST_LEN(8)) DUT (.*);
    aob_capture_model cap_model (.sample_strobe_a_out(sample_strobe_a_out),
        .data_a_out(data_a_out), .cap_a(cap_a));
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] ch);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_chan = ch;
        reg_wr = 1;
        @(posedge clk);
        #1;
        reg_wr = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1;
        reg_addr = a;
        @(posedge clk);
        #1;
        `CHK(reg_rdata, exp)
    endtask
    task automatic links(input int k);
        repeat (k) @(posedge link_clk);
        #1;
    endtask
    // Counts link edges from a new input word until it shows on bus A.
    task automatic latency(input logic [12:0] v, input logic [12:0] exp);
        int k;
        k = 0;
        links(1);
        {conv_a_ovr, conv_a} = v;
        while (data_a_out !== exp && k < 30)
        begin
            links(1);
            k++;
        end
        `CHK(k inside {[19:20]}, 1'b1)
        links(4);
        `CHK(cap_a, exp)
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            print_verdict();
        end
    end
    initial
    begin
        repeat (2) @(posedge clk);
        #1;
        sys_rst = 0;
        links(40);
        rd(aob_pkg::OFS_TEST_PATTERN, aob_pkg::RST_TEST_PATTERN);
        rd(aob_pkg::OFS_BIST_CTRL, aob_pkg::RST_BIST_CTRL);
        rd(aob_pkg::OFS_OUT_MODE, aob_pkg::RST_OUT_MODE);
        rd(8'h30, 8'h00);
        wr(aob_pkg::OFS_BIST_STATUS, 8'hFF, 2'b11);
        rd(aob_pkg::OFS_BIST_STATUS, 8'h00);
        for (int f = 0; f < 3; f++)
        begin
            wr(aob_pkg::OFS_OUT_MODE, 8'(f), 2'b11);
            links(6);
            latency(lin[f], lexp[f]);
            `CHK(data_b_out, bexp[f])
        end
        serial_mode = 0;
        format_select_strap = 1;
        links(6);
        latency(13'h0123, 13'h0923);
        format_select_strap = 0;
        links(6);
        latency(13'h0456, 13'h0456);
        serial_mode = 1;
        output_disable = 1;
        links(6);
        `CHK({data_a_oe, data_b_oe, sample_strobe_a_oe, sample_strobe_b_oe}, 4'h0)
        output_disable = 0;
        links(6);
        `CHK({data_a_oe, data_b_oe, sample_strobe_a_oe, sample_strobe_b_oe}, 4'hF)
        wr(aob_pkg::OFS_OUT_MODE, 8'h80, 2'b01);
        wr(aob_pkg::OFS_OUT_MODE, 8'h22, 2'b10);
        links(30);
        v1 = data_a_out;
        links(1);
        `CHK((v1 == 13'h0456 && data_a_out == 13'h01B2) || (v1 == 13'h01B2 && data_a_out == 13'h0456), 1'b1)
        `CHK(sample_strobe_b_out, ~sample_strobe_a_out)
        wr(aob_pkg::OFS_OUT_MODE, 8'h10, 2'b01);
        links(6);
        `CHK({data_a_oe, data_b_oe, sample_strobe_a_oe, sample_strobe_b_oe}, 4'h5)
        wr(aob_pkg::OFS_BIST_CTRL, 8'h05, 2'b00);
        rd(aob_pkg::OFS_BIST_STATUS, 8'h02);
        links(4);
        `CHK(data_a_oe, 1'b1)
        n = 0;
        while (reg_rdata[aob_pkg::BIT_BIST_BUSY] !== 1'b0 && n < 200)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(n < 200, 1'b1)
        rd(aob_pkg::OFS_BIST_STATUS, 8'h00);
        links(6);
        `CHK(data_a_oe, 1'b0)
        wr(aob_pkg::OFS_OUT_MODE, 8'h00, 2'b11);
        for (int p = 0; p < 3; p++)
        begin
            wr(aob_pkg::OFS_TEST_PATTERN, {4'h0, pats[p]}, 2'b00);
            links(30);
            `CHK(cap_a, {1'b0, pexp[p]})
        end
        wr(aob_pkg::OFS_OUT_MODE, 8'h01, 2'b01);
        wr(aob_pkg::OFS_TEST_PATTERN, {4'h0, aob_pkg::PAT_CHECKER}, 2'b00);
        links(30);
        v1 = cap_a;
        links(2);
        `CHK((v1 == 13'h0555 && cap_a == 13'h0AAA) || (v1 == 13'h0AAA && cap_a == 13'h0555), 1'b1)
        wr(aob_pkg::OFS_TEST_PATTERN, {4'h1, aob_pkg::PAT_PN_LONG}, 2'b00);
        links(30);
        `CHK(cap_a, 13'h07FF)
        wr(aob_pkg::OFS_TEST_PATTERN, 8'h00, 2'b00);
        print_verdict();
    end
endmodule
`default_nettype wire
